// [test/ircr_core_model.sv]
`timescale 1ns/10ps
// ****
// Drive core model: answers each presented instruction
// ****
module ircr_core_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic cmd_valid_i, // Instruction presented
   input wire logic [7:0] cmd_code_i, // Instruction code
   input wire logic [7:0] cmd_ext_i, // Extended setting
   input wire logic [15:0] cmd_operand_i, // Operand
   input wire logic [1:0] lat_i, // Answer delay
   output logic cmd_done_o = 1'b0, // Finished pulse
   output logic [15:0] cmd_reply_o // Reply code
);
   logic [1:0] wait_cnt = 2'h0;
   logic [15:0] answer;
   // Reply is zero only when the operand mirrors the code word
   assign answer = {cmd_ext_i, cmd_code_i} ^ cmd_operand_i;
   // Reply is only meaningful with done; otherwise show its inverse
   assign cmd_reply_o = cmd_done_o ? answer : ~answer;
   // One done pulse per instruction, lat_i + 1 cycles after valid
   always_ff @(posedge clk_i) begin
      if (rst_i || !cmd_valid_i || cmd_done_o) begin
         wait_cnt <= 2'h0;
         cmd_done_o <= 1'b0;
      end else if (wait_cnt == lat_i) begin
         cmd_done_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// [test/tb_inverter_remote_cmd_registers.sv]
`timescale 1ns/10ps
module tb_inverter_remote_cmd_registers;
   import ircr_pkg::*;
   // ****
   // Signals
   // ****
   localparam logic [15:0] TMA = 16'h0fa0;
   localparam logic [15:0] TMB = 16'h07d0;
   logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, prev_valid = 0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0, wb_dat_o;
   logic wb_ack_o, cmd_valid_o, cmd_done, ram_store_o, nv_store_o, reverse_o;
   logic [2:0] cmd_slot_o;
   logic [2:0] log_slot [0:15];
   logic [7:0] cmd_code_o, cmd_ext_o;
   logic [15:0] cmd_operand_o, cmd_reply, freq_cmd_o, q, ht = 0, hf = 0, he = 0, tq = 0;
   logic [15:0] seed = 16'h0059;
   logic [15:0] log_word [0:15], log_op [0:15], code [0:5], op [0:5];
   logic [1:0] lat = 2'h0;
   int miscompares = 0, samples_checked = 0, cycles = 0, nlog = 0, n_ram = 0, n_nv = 0;
   // ****
   // Clock, design and core model
   // ****
   always #5 clk_i = ~clk_i;
   ircr_top #(.TQ_MAX_A(TMA), .TQ_MAX_B(TMB)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .cmd_valid_o(cmd_valid_o), .cmd_slot_o(cmd_slot_o), .cmd_code_o(cmd_code_o),
      .cmd_ext_o(cmd_ext_o), .cmd_operand_o(cmd_operand_o), .cmd_done_i(cmd_done),
      .cmd_reply_i(cmd_reply), .ram_store_o(ram_store_o), .nv_store_o(nv_store_o),
      .reverse_o(reverse_o), .freq_cmd_o(freq_cmd_o));
   ircr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_o),
      .cmd_code_i(cmd_code_o), .cmd_ext_i(cmd_ext_o), .cmd_operand_i(cmd_operand_o),
      .lat_i(lat), .cmd_done_o(cmd_done), .cmd_reply_o(cmd_reply));
   // Logs issued instructions, counts store pulses, cuts a hang short
   always @(posedge clk_i) begin
      if (cmd_valid_o === 1'b1 && prev_valid !== 1'b1 && nlog < 16) begin
         log_slot[nlog] = cmd_slot_o;
         log_word[nlog] = {cmd_ext_o, cmd_code_o};
         log_op[nlog] = cmd_operand_o;
         nlog++;
      end
      prev_valid = cmd_valid_o;
      if (ram_store_o === 1'b1) n_ram++;
      if (nv_store_o === 1'b1) n_nv++;
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         stop_test();
      end
   end
   // ****
   // Helpers
   // ****
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   // Corner percentages mixed with random in-range values
   function automatic logic [15:0] pick();
      logic [15:0] r;
      r = rnd();
      case (r[2:0])
         3'h0: return 16'h0000;
         3'h1: return PID_FULL;
         3'h2: return PID_FULL + 16'h0001;
         3'h3: return PID_NEG;
         3'h4: return PID_NEG - 16'h0001;
         default: return r[15] ? 16'h0000 - (r % 16'h2711) : r % 16'h2711;
      endcase
   endfunction
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   // One classic Wishbone cycle; read data lands in q
   task automatic bus(input logic we, input logic [5:0] w, input logic [15:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {w, 2'b00};
      wb_dat <= {16'h0000, d};
      wb_sel <= 4'h3;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o[15:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic store(input int b);
      int r, n;
      r = n_ram;
      n = n_nv;
      bus(1'b1, W_CTRL, 16'h0001 << b);
      bus(1'b1, W_CTRL, 16'h0000);
      chk(n_ram == r + (b == C_RAM) && n_nv == n + (b == C_NV), "store pulse");
   endtask
   task automatic pid_try();
      logic [15:0] acts [0:8];
      logic [15:0] a, s, t, f, e;
      logic all, rng;
      acts = '{PA_50, PA_51, PA_60, PA_61, PA_LO, PA_HI, 16'h0034, 16'h07dc, 16'h03e7};
      a = acts[rnd() % 9];
      s = rnd() & 16'h00c0;
      t = pick();
      f = pick();
      e = pick();
      all = a inside {PA_50, PA_51, PA_60, PA_61};
      rng = a >= PA_LO && a <= PA_HI;
      bus(1'b1, W_PIDSEL, a);
      bus(1'b1, W_SEL, s);
      bus(1'b1, W_TGT, t);
      bus(1'b1, W_FB, f);
      bus(1'b1, W_ERR, e);
      store(C_RAM);
      if ((all || (rng && s[S_SPSRC])) && t <= PID_FULL) ht = t;
      if ((all || (rng && s[S_FBSRC])) && f <= PID_FULL) hf = f;
      if ((all || (rng && s[S_FBSRC])) && $signed(e) >= $signed(PID_NEG)
          && $signed(e) <= $signed(PID_FULL)) he = e;
      bus(1'b0, W_HTGT, 16'h0000);
      chk(q === ht, "held target");
      bus(1'b0, W_HFB, 16'h0000);
      chk(q === hf, "held feedback");
      bus(1'b0, W_HERR, 16'h0000);
      chk(q === he, "held deviation");
   endtask
   task automatic tq_try(input int b);
      logic [15:0] r, s, v, m, mx;
      logic ok, lim;
      r = rnd();
      s = 16'h0000;
      s[2:0] = r[2] ? r[5:3] : (r[0] ? TQ_SRC_A : TQ_SRC_B);
      s[4:3] = r[6] ? r[8:7] : TQ_LIM_REG;
      s[S_TQMODE] = r[9];
      mx = (s[2:0] == TQ_SRC_A) ? TMA : TMB;
      v = (r[11:10] == 2'h0) ? mx : (r[11:10] == 2'h1) ? mx + 16'h0001 : rnd() % mx;
      if (!s[S_TQMODE] && r[12]) v = 16'h0000 - v;
      m = v[15] ? 16'h0000 - v : v;
      ok = s[2:0] inside {TQ_SRC_A, TQ_SRC_B} && m <= mx;
      lim = ok && !s[S_TQMODE] && s[4:3] == TQ_LIM_REG;
      bus(1'b1, W_SEL, s);
      bus(1'b1, W_TQ, v);
      bus(1'b0, W_TQRAM, 16'h0000);
      chk(q === tq, "torque taken without request");
      store(b);
      if ((ok && s[S_TQMODE]) || lim) tq = m;
      bus(1'b0, W_TQRAM, 16'h0000);
      chk(q === tq, "volatile torque value");
      bus(1'b0, W_TQNV, 16'h0000);
      chk(q === tq, "nonvolatile torque value");
      if (lim) begin
         bus(1'b0, W_TQLIM, 16'h0000);
         chk(q === m, "torque limit magnitude");
      end
   endtask
   task automatic ins_run(input logic run);
      logic [5:0] off;
      logic [15:0] r;
      int n, e;
      off = run ? 6'b001010 : 6'b100101;
      for (int k = 0; k < NSLOT; k++) begin
         code[k] = off[k] ? CODE_OFF : rnd();
         op[k] = off[k] ? 16'h0000 : (run && k == 4) ? code[k] : rnd();
         bus(1'b1, W_SLOT + 6'(2 * k), code[k]);
         bus(1'b1, W_SLOT + 6'(2 * k + 1), op[k]);
      end
      r = rnd();
      lat <= r[1:0];
      nlog = 0;
      bus(1'b1, W_CTRL, 16'h0004);
      n = 0;
      do begin
         bus(1'b0, W_STAT, 16'h0000);
         n++;
      end while (q[0] !== 1'b1 && n < 100);
      chk(q[0] === 1'b1, "instruction completion");
      e = 0;
      for (int k = 0; k < NSLOT; k++) begin
         if (k == 0 || code[k] !== CODE_OFF) begin
            chk(log_slot[e] === 3'(k) && log_word[e] === code[k] && log_op[e] === op[k],
                "slot issue");
            e++;
         end
         bus(1'b0, W_REPLY + 6'(k), 16'h0000);
         chk(q === ((k == 0 || code[k] !== CODE_OFF) ? code[k] ^ op[k] : 16'h0000),
             "slot reply");
      end
      chk(nlog == e, "issue count");
      bus(1'b1, W_CTRL, 16'h0004);
      repeat (30) @(posedge clk_i);
      chk(nlog == e, "held request reran");
      bus(1'b1, W_CTRL, 16'h0000);
   endtask
   task automatic stop_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      logic [15:0] fv [0:4];
      logic [15:0] fe [0:4];
      logic [4:0] fs, fr;
      fv = '{FREQ_MAX, FREQ_MAX + 16'h0001, 16'hfffb, 16'h8000, 16'h7fff};
      fe = '{FREQ_MAX, FREQ_MAX, 16'h0005, 16'h8000, 16'h7fff};
      fs = 5'b11100;
      fr = 5'b01100;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 6'h3f, 16'h0000);
      chk(q === 16'h0000, "unmapped read");
      for (int i = 0; i < 24; i++) pid_try();
      for (int i = 0; i < 16; i++) tq_try(i % 2);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, W_SEL, 16'(fs[i]) << S_FSIGN);
         bus(1'b1, W_FREQ, fv[i]);
         store(C_RAM);
         chk(freq_cmd_o === fe[i] && reverse_o === fr[i], "frequency output");
         bus(1'b0, W_HFREQ, 16'h0000);
         chk(q === fe[i], "held frequency");
      end
      ins_run(1'b0);
      ins_run(1'b1);
      stop_test();
   end
endmodule

// [verilog/ircr_pkg.sv]
package ircr_pkg;
   // ***********************************************
   // Word addresses (byte address bits 7:2)
   // ***********************************************
   localparam logic [5:0] W_CTRL = 6'h00;
   localparam logic [5:0] W_STAT = 6'h01;
   localparam logic [5:0] W_PIDSEL = 6'h02;
   localparam logic [5:0] W_SEL = 6'h03;
   localparam logic [5:0] W_TGT = 6'h04;
   localparam logic [5:0] W_FB = 6'h05;
   localparam logic [5:0] W_ERR = 6'h06;
   localparam logic [5:0] W_TQ = 6'h07;
   localparam logic [5:0] W_FREQ = 6'h08;
   localparam logic [5:0] W_HTGT = 6'h09;
   localparam logic [5:0] W_HFB = 6'h0a;
   localparam logic [5:0] W_HERR = 6'h0b;
   localparam logic [5:0] W_TQRAM = 6'h0c;
   localparam logic [5:0] W_TQNV = 6'h0d;
   localparam logic [5:0] W_TQLIM = 6'h0e;
   localparam logic [5:0] W_HFREQ = 6'h0f;
   localparam logic [5:0] W_SLOT = 6'h10;
   localparam logic [5:0] W_REPLY = 6'h20;
   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int C_RAM = 0;
   localparam int C_NV = 1;
   localparam int C_INS = 2;
   localparam int S_TQSRC = 0;
   localparam int S_TQLIM = 3;
   localparam int S_TQMODE = 5;
   localparam int S_SPSRC = 6;
   localparam int S_FBSRC = 7;
   localparam int S_FSIGN = 8;
   // ***********************************************
   // Values and limits
   // ***********************************************
   localparam int NSLOT = 6;
   localparam logic [2:0] LAST_SLOT = 3'h5;
   localparam logic [15:0] CODE_OFF = 16'hffff;
   localparam logic [15:0] PID_FULL = 16'h2710;
   localparam logic [15:0] PID_NEG = 16'hd8f0;
   localparam logic [15:0] FREQ_MAX = 16'he678;
   localparam logic [15:0] PA_50 = 16'h0032;
   localparam logic [15:0] PA_51 = 16'h0033;
   localparam logic [15:0] PA_60 = 16'h003c;
   localparam logic [15:0] PA_61 = 16'h003d;
   localparam logic [15:0] PA_LO = 16'h03e8;
   localparam logic [15:0] PA_HI = 16'h07db;
   localparam logic [2:0] TQ_SRC_A = 3'h3;
   localparam logic [2:0] TQ_SRC_B = 3'h5;
   localparam logic [1:0] TQ_LIM_REG = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ISSUE = 2'h1,
      ST_WAIT = 2'h3,
      ST_DONE = 2'h2
   } ircr_state_t;
endpackage

// [verilog/ircr_top.sv]
`timescale 1ns/10ps
module ircr_top import ircr_pkg::*; #(
   parameter logic [15:0] TQ_MAX_A = 16'h0fa0,
   parameter logic [15:0] TQ_MAX_B = 16'h07d0
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Sync reset
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Write
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   output logic cmd_valid_o, // Instruction to core
   output logic [2:0] cmd_slot_o, // Slot index
   output logic [7:0] cmd_code_o, // Instruction code
   output logic [7:0] cmd_ext_o, // Extended setting
   output logic [15:0] cmd_operand_o, // Operand
   input wire logic cmd_done_i, // Core finished
   input wire logic [15:0] cmd_reply_i, // Core reply
   output logic ram_store_o, // Volatile store pulse
   output logic nv_store_o, // Nonvolatile store pulse
   output logic reverse_o, // Run reversed
   output logic [15:0] freq_cmd_o // Frequency magnitude
);
   // ***********************************************
   // Storage
   // ***********************************************
   logic [2:0] ctrl;
   logic [2:0] ctrl_prev;
   logic [15:0] pid_action_select;
   logic [15:0] sel_reg;
   logic [15:0] pid_target;
   logic [15:0] pid_feedback;
   logic [15:0] pid_error_input;
   logic [15:0] torque_command_or_limit;
   logic [15:0] set_freq;
   logic [15:0] h_tgt;
   logic [15:0] h_fb;
   logic [15:0] h_err;
   logic [15:0] torque_cmd_ram_param;
   logic [15:0] torque_cmd_nv_param;
   logic [15:0] tq_limit;
   logic [15:0] slot_code [NSLOT];
   logic [15:0] slot_opnd [NSLOT];
   logic [15:0] reply [NSLOT];
   logic instruction_complete;
   ircr_state_t state;
   ircr_state_t next_state;
   logic [2:0] slot;

   // ***********************************************
   // Bus decode
   // ***********************************************
   // Access taken in the cycle before ack rises
   wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = acc & wb_we_i;
   wire [5:0] wadr = wb_adr_i[7:2];
   wire [1:0] wsel = wb_sel_i[1:0];

   // Byte lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                         input logic [1:0] s);
      merge = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   wire [15:0] wd = wb_dat_i[15:0];
   wire wr_ctrl = wr & (wadr == W_CTRL);
   wire wr_psel = wr & (wadr == W_PIDSEL);
   wire wr_sel = wr & (wadr == W_SEL);
   wire wr_tgt = wr & (wadr == W_TGT);
   wire wr_fb = wr & (wadr == W_FB);
   wire wr_err = wr & (wadr == W_ERR);
   wire wr_tq = wr & (wadr == W_TQ);
   wire wr_freq = wr & (wadr == W_FREQ);

   // ***********************************************
   // Request edges
   // ***********************************************
   wire [2:0] req_rise = ctrl & ~ctrl_prev;
   wire apply = req_rise[C_RAM] | req_rise[C_NV];
   wire ins_start = req_rise[C_INS] & (state == ST_IDLE);

   // Control bits and their previous values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= 3'h0;
         ctrl_prev <= 3'h0;
      end else begin
         if (wr_ctrl && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[2:0];
         end
         ctrl_prev <= ctrl;
      end
   end

   // Configuration and raw remote registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pid_action_select <= 16'h0000;
         sel_reg <= 16'h0000;
         pid_target <= 16'h0000;
         pid_feedback <= 16'h0000;
         pid_error_input <= 16'h0000;
         torque_command_or_limit <= 16'h0000;
         set_freq <= 16'h0000;
      end else begin
         if (wr_psel) pid_action_select <= merge(pid_action_select, wd, wsel);
         if (wr_sel) sel_reg <= merge(sel_reg, wd, wsel);
         if (wr_tgt) pid_target <= merge(pid_target, wd, wsel);
         if (wr_fb) pid_feedback <= merge(pid_feedback, wd, wsel);
         if (wr_err) pid_error_input <= merge(pid_error_input, wd, wsel);
         if (wr_tq) torque_command_or_limit <= merge(torque_command_or_limit, wd, wsel);
         if (wr_freq) set_freq <= merge(set_freq, wd, wsel);
      end
   end

   // Instruction slots: code at even word, operand at next
   generate
      for (genvar k = 0; k < NSLOT; k++) begin : g_slot
         localparam logic [5:0] WC = W_SLOT + 6'(2 * k);
         localparam logic [5:0] WO = W_SLOT + 6'(2 * k + 1);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               slot_code[k] <= 16'h0000;
               slot_opnd[k] <= 16'h0000;
            end else begin
               if (wr && wadr == WC) slot_code[k] <= merge(slot_code[k], wd, wsel);
               if (wr && wadr == WO) slot_opnd[k] <= merge(slot_opnd[k], wd, wsel);
            end
         end
      end
   endgenerate

   // ***********************************************
   // PID input validation
   // ***********************************************
   wire pa_fixed = (pid_action_select == PA_50) | (pid_action_select == PA_51) |
                   (pid_action_select == PA_60) | (pid_action_select == PA_61);
   wire pa_range = (pid_action_select >= PA_LO) & (pid_action_select <= PA_HI);
   wire sp_on = pa_fixed | (pa_range & sel_reg[S_SPSRC]);
   wire fb_on = pa_fixed | (pa_range & sel_reg[S_FBSRC]);
   wire tgt_ok = ~pid_target[15] & (pid_target <= PID_FULL);
   wire fb_ok = ~pid_feedback[15] & (pid_feedback <= PID_FULL);
   wire err_ok = $signed(pid_error_input) >= $signed(PID_NEG) &&
                 $signed(pid_error_input) <= $signed(PID_FULL);

   // Held PID inputs, updated on a store request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         h_tgt <= 16'h0000;
         h_fb <= 16'h0000;
         h_err <= 16'h0000;
      end else if (apply) begin
         if (sp_on && tgt_ok) h_tgt <= pid_target;
         if (fb_on && fb_ok) h_fb <= pid_feedback;
         if (fb_on && err_ok) h_err <= pid_error_input;
      end
   end

   // ***********************************************
   // Torque command and limit
   // ***********************************************
   wire [2:0] tq_src = sel_reg[S_TQSRC +: 3];
   wire tq_src_ok = (tq_src == TQ_SRC_A) | (tq_src == TQ_SRC_B);
   wire tq_mode = sel_reg[S_TQMODE];
   wire tq_is_cmd = tq_mode & tq_src_ok;
   wire tq_is_lim = ~tq_mode & tq_src_ok & (sel_reg[S_TQLIM +: 2] == TQ_LIM_REG);
   wire [15:0] tq_max = (tq_src == TQ_SRC_A) ? TQ_MAX_A : TQ_MAX_B;
   wire [15:0] tq_abs = torque_command_or_limit[15] ?
                        16'(-torque_command_or_limit) : torque_command_or_limit;
   wire tq_ok = ~tq_abs[15] & (tq_abs <= tq_max);
   wire tq_take_cmd = apply & tq_is_cmd & tq_ok;
   wire tq_take_lim = apply & tq_is_lim & tq_ok;
   wire [15:0] tq_val = tq_is_cmd ? torque_command_or_limit : tq_abs;

   // Both torque parameters move together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         torque_cmd_ram_param <= 16'h0000;
         torque_cmd_nv_param <= 16'h0000;
         tq_limit <= 16'h0000;
      end else begin
         if (tq_take_cmd || tq_take_lim) begin
            torque_cmd_ram_param <= tq_val;
            torque_cmd_nv_param <= tq_val;
         end
         if (tq_take_lim) tq_limit <= tq_abs;
      end
   end

   // ***********************************************
   // Frequency and store pulses
   // ***********************************************
   wire fsign = sel_reg[S_FSIGN];
   wire [15:0] f_abs = set_freq[15] ? 16'(-set_freq) : set_freq;
   wire f_ok = fsign | (set_freq <= FREQ_MAX);

   // Frequency held as direction plus magnitude
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reverse_o <= 1'b0;
         freq_cmd_o <= 16'h0000;
         ram_store_o <= 1'b0;
         nv_store_o <= 1'b0;
      end else begin
         ram_store_o <= req_rise[C_RAM];
         nv_store_o <= req_rise[C_NV];
         if (apply && f_ok) begin
            reverse_o <= fsign & set_freq[15];
            freq_cmd_o <= fsign ? f_abs : set_freq;
         end
      end
   end

   // ***********************************************
   // Instruction sequencer
   // ***********************************************
   wire skip = (slot != 3'h0) & (slot_code[slot] == CODE_OFF);
   wire last = (slot == LAST_SLOT);

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (ins_start) next_state = ST_ISSUE;
         ST_ISSUE: begin
            if (!skip) next_state = ST_WAIT;
            else if (last) next_state = ST_DONE;
         end
         ST_WAIT: if (cmd_done_i) next_state = last ? ST_DONE : ST_ISSUE;
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Slot walk, command outputs and replies
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         slot <= 3'h0;
         cmd_valid_o <= 1'b0;
         cmd_slot_o <= 3'h0;
         cmd_code_o <= 8'h00;
         cmd_ext_o <= 8'h00;
         cmd_operand_o <= 16'h0000;
         instruction_complete <= 1'b0;
         for (int i = 0; i < NSLOT; i++) reply[i] <= 16'h0000;
      end else begin
         state <= next_state;
         if (ins_start) begin
            slot <= 3'h0;
            instruction_complete <= 1'b0;
            for (int i = 0; i < NSLOT; i++) reply[i] <= 16'h0000;
         end
         if (state == ST_ISSUE) begin
            if (!skip) begin
               cmd_valid_o <= 1'b1;
               cmd_slot_o <= slot;
               cmd_code_o <= slot_code[slot][7:0];
               cmd_ext_o <= slot_code[slot][15:8];
               cmd_operand_o <= slot_opnd[slot];
            end else if (!last) begin
               slot <= slot + 3'h1;
            end
         end
         if (state == ST_WAIT && cmd_done_i) begin
            cmd_valid_o <= 1'b0;
            reply[slot] <= cmd_reply_i;
            if (!last) slot <= slot + 3'h1;
         end
         if (state == ST_DONE) instruction_complete <= 1'b1;
      end
   end

   // ***********************************************
   // Read back
   // ***********************************************
   wire [2:0] ridx = 3'(wadr[3:1]);
   wire in_slot = (wadr >= W_SLOT) & (wadr < W_SLOT + 6'(2 * NSLOT));
   wire [2:0] rrep = wadr[2:0];
   wire in_rep = (wadr >= W_REPLY) & (wadr < W_REPLY + 6'(NSLOT));
   wire [15:0] stat = {13'h0000, reverse_o, (state != ST_IDLE), instruction_complete};
   wire [15:0] rd_fix =
      (wadr == W_CTRL) ? {13'h0000, ctrl} :
      (wadr == W_STAT) ? stat :
      (wadr == W_PIDSEL) ? pid_action_select :
      (wadr == W_SEL) ? sel_reg :
      (wadr == W_HTGT) ? h_tgt :
      (wadr == W_HFB) ? h_fb :
      (wadr == W_HERR) ? h_err :
      (wadr == W_TQRAM) ? torque_cmd_ram_param :
      (wadr == W_TQNV) ? torque_cmd_nv_param :
      (wadr == W_TQLIM) ? tq_limit :
      (wadr == W_HFREQ) ? freq_cmd_o : 16'h0000;
   wire [15:0] rd_word = in_slot ? (wadr[0] ? slot_opnd[ridx] : slot_code[ridx]) :
                         in_rep ? reply[rrep] : rd_fix;

   // Single-wait-state slave
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) wb_dat_o <= {16'h0000, rd_word};
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_issue_primary;
      (state == ST_ISSUE) && (slot == 3'h0);
   endsequence
   sequence s_cmd_primary;
      cmd_valid_o && (cmd_slot_o == 3'h0);
   endsequence

   a_primary_always: assert property (s_issue_primary |=> s_cmd_primary)
      else $error("primary instruction not issued");
   a_start_primary: assert property (ins_start |=> ##1 s_cmd_primary)
      else $error("sequence did not begin at primary");
   a_skip_disabled: assert property ((state == ST_ISSUE) && skip |=> !cmd_valid_o)
      else $error("disabled slot was issued");
   a_complete_last: assert property ($rose(instruction_complete) |->
      $past(state) == ST_DONE && $past(slot) == LAST_SLOT)
      else $error("completion without last slot");
   a_slot_ascend: assert property ((state == ST_WAIT) && cmd_done_i && !last |=>
      slot == $past(slot) + 3'h1)
      else $error("slot order broken");
   a_edge_once: assert property (ins_start |->
      $past(wr_ctrl && wb_sel_i[0] && wb_dat_i[C_INS]) && !$past(ctrl[C_INS]))
      else $error("held request restarted");
   a_tgt_range: assert property (h_tgt <= PID_FULL)
      else $error("target out of range held");
   a_tq_both: assert property (torque_cmd_ram_param == torque_cmd_nv_param)
      else $error("torque parameters differ");
   a_tq_request: assert property (!apply |=> $stable(torque_cmd_ram_param))
      else $error("torque changed without request");
   a_nv_store: assert property (req_rise[C_NV] |=> nv_store_o ##1 !nv_store_o)
      else $error("nonvolatile store pulse wrong");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_reverse_sign: assert property ($rose(reverse_o) |->
      $past(apply && fsign && set_freq[15]))
      else $error("reverse without signed mode");
endmodule
